// *** pkg/srpc_pkg.sv ***
// Constants, types and field layout of the standby, reset and power block.
// Assumes a single clock domain (mclk) and an Avalon-MM register slave.
package srpc_pkg;

    // ==========================================================
    // Counter widths and taps
    localparam int PS_WIDTH = 11;
    localparam int BIT_WIDTH = 8;
    localparam int TAP_BASE = 3;
    localparam logic [2:0] SEL_TAP_TEN = 3'h7;
    localparam logic [31:0] POR_CYCLES = 32'h0008_0000;
    localparam int SYNC_STAGES = 2;

    // ==========================================================
    // Register offsets (byte addresses) and reset values
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_LVI = 5'h04;
    localparam logic [4:0] OFF_IRQ_STAT = 5'h08;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h0c;
    localparam logic [4:0] OFF_STATE = 5'h10;
    localparam logic [2:0] RST_INTERVAL_SEL = 3'h7;
    localparam logic RST_PERIPH_EN = 1'b1;
    localparam logic [3:0] RST_IRQ_MASK = 4'h0;

    // ==========================================================
    // Control field positions and event bits
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_PCK_BIT = 3;
    localparam int EVT_WAKE = 0;
    localparam int EVT_REFUSED = 1;
    localparam int EVT_BROWNOUT = 2;
    localparam int EVT_POR_DONE = 3;
    localparam int EVT_COUNT = 4;

    // ==========================================================
    // Types
    typedef enum logic [4:0] {
        ST_RUN = 5'b00001,
        ST_SLEEP = 5'b00010,
        ST_STOP = 5'b00100,
        ST_STAB = 5'b01000,
        ST_POR = 5'b10000
    } srpc_state_t;

    typedef struct packed {
        logic porPulse;
        logic oscStarted;
        logic extResetB;
        logic supplyLow;
        logic belowHigh;
        logic belowLow;
    } srpc_pins_t;

    typedef struct packed {
        logic cpuClkEn;
        logic prescalerRun;
        logic intervalRun;
        logic periphClkEn;
        logic watchdogRun;
        logic timerRun;
    } srpc_clocks_t;

    typedef struct packed {
        logic oscRun;
        logic xoutHigh;
        logic xinLow;
        logic feedbackEn;
    } srpc_osc_t;

endpackage

// *** src/srpc_ctrl.sv ***
// Standby, reset stretch, brownout and supply indicator controller.
// Assumes pins arrive asynchronous, CPU strobes arrive on mclk.
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module srpc_ctrl #(
    parameter int IRQ_COUNT = 8,
    parameter int BIT_WIDTH = srpc_pkg::BIT_WIDTH
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clkEn,
    // Avalon-MM slave
    input wire logic [4:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    // Asynchronous pins
    input wire srpc_pkg::srpc_pins_t pins,
    // CPU side
    input wire logic sleepCmd,
    input wire logic stopCmd,
    input wire logic globalIrqEn,
    input wire logic [IRQ_COUNT-1:0] irqReq,
    input wire logic [IRQ_COUNT-1:0] irqEnable,
    output logic resumeNext,
    output logic vectorTake,
    output logic [$clog2(IRQ_COUNT)-1:0] vectorIndex,
    output logic sysReset,
    // Clocks, oscillator, ports
    output srpc_pkg::srpc_clocks_t clocks,
    output srpc_pkg::srpc_osc_t osc,
    output logic portsAllInput,
    output logic brownoutMode,
    output logic irq
);
    localparam int VW = $clog2(IRQ_COUNT);
    // Power-on length: carry period of tap ten times interval count
    localparam int POR_LOG2 = srpc_pkg::TAP_BASE
        + int'(srpc_pkg::SEL_TAP_TEN) + 1 + BIT_WIDTH;
    localparam logic [31:0] POR_LEN = 32'h1 << POR_LOG2;

    // ==========================================================
    // Helpers
    // Lowest pending enabled interrupt
    function automatic logic [VW-1:0] firstSet(
        input logic [IRQ_COUNT-1:0] v);
        logic [VW-1:0] idx;
        idx = '0;
        for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = VW'(i);
            end
        end
        return idx;
    endfunction

    // ==========================================================
    // Pin synchronisers
    srpc_pkg::srpc_pins_t pinMeta_q;
    srpc_pkg::srpc_pins_t pinSync_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            // Reset pin idles high; a zero would fake a pin reset
            pinMeta_q <= '{extResetB: 1'b1, default: 1'b0};
            pinSync_q <= '{extResetB: 1'b1, default: 1'b0};
        end else if (clkEn) begin
            pinMeta_q <= pins;
            pinSync_q <= pinMeta_q;
        end
    end

    // ==========================================================
    // Registers and state
    srpc_pkg::srpc_state_t state_q, state_d;
    logic [2:0] intervalSel_q;
    logic periphEn_q;
    logic [1:0] lvi_q;
    logic [3:0] irqStat_q;
    logic [3:0] irqMask_q;
    logic brownout_q;
    logic stopWakeOk_q;
    logic [srpc_pkg::PS_WIDTH-1:0] psCnt_q;
    logic [BIT_WIDTH-1:0] bitCnt_q;
    logic tapPrev_q;
    logic ovfSeen_q;

    // Decoded conditions
    logic [IRQ_COUNT-1:0] pend;
    logic anyPend, extRstLow, porSeen, quiet;
    logic [3:0] tapIdx;
    logic tapNow, bitTick, bitOvf, psRun, bitRun;
    logic wakeSleep, wakeStop, refuse, lowEvt;
    logic [3:0] evt;

    assign pend = irqReq & irqEnable;
    assign anyPend = |pend;
    assign extRstLow = !pinSync_q.extResetB;
    assign porSeen = pinSync_q.porPulse;
    assign lowEvt = pinSync_q.supplyLow && !brownout_q;
    assign quiet = !extRstLow && !porSeen && !lowEvt;

    // Prescaler runs except in stop; waits for oscillation in power-on
    assign psRun = (state_q == srpc_pkg::ST_POR) ?
        (pinSync_q.oscStarted && !porSeen) :
        (state_q != srpc_pkg::ST_STOP);

    // Interval timer tap select, forced to tap ten in power-on
    assign tapIdx = (state_q == srpc_pkg::ST_POR) ?
        4'(srpc_pkg::TAP_BASE) + 4'(srpc_pkg::SEL_TAP_TEN) :
        4'(srpc_pkg::TAP_BASE) + {1'b0, intervalSel_q};
    assign tapNow = psCnt_q[tapIdx];
    assign bitRun = psRun && ((state_q != srpc_pkg::ST_SLEEP)
        || (intervalSel_q == srpc_pkg::SEL_TAP_TEN));
    // Carry out of the tap so the full count is a power of two
    assign bitTick = bitRun && tapPrev_q && !tapNow;
    assign bitOvf = bitTick && (&bitCnt_q);

    // Standby requests and wake conditions
    assign refuse = (state_q == srpc_pkg::ST_RUN)
        && (sleepCmd || stopCmd) && anyPend;
    assign wakeSleep = (state_q == srpc_pkg::ST_SLEEP) && anyPend;
    assign wakeStop = (state_q == srpc_pkg::ST_STOP) && anyPend
        && stopWakeOk_q && !brownout_q;

    // ==========================================================
    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            srpc_pkg::ST_RUN: begin
                if (!anyPend && stopCmd) begin
                    state_d = srpc_pkg::ST_STOP;
                end else if (!anyPend && sleepCmd) begin
                    state_d = srpc_pkg::ST_SLEEP;
                end
            end
            srpc_pkg::ST_SLEEP: begin
                if (wakeSleep) begin
                    state_d = srpc_pkg::ST_RUN;
                end
            end
            srpc_pkg::ST_STOP: begin
                if (wakeStop) begin
                    state_d = srpc_pkg::ST_STAB;
                end
            end
            srpc_pkg::ST_STAB: begin
                if (bitOvf && !extRstLow) begin
                    state_d = srpc_pkg::ST_RUN;
                end
            end
            srpc_pkg::ST_POR: begin
                if (bitOvf) begin
                    state_d = srpc_pkg::ST_RUN;
                end
            end
            default: begin
                state_d = srpc_pkg::ST_POR;
            end
        endcase
        // Supply drop parks the device in stop
        if (lowEvt) begin
            state_d = srpc_pkg::ST_STOP;
        end
        // External reset; stop needs the stabilization interval
        if (extRstLow) begin
            state_d = (state_q == srpc_pkg::ST_STOP
                || state_q == srpc_pkg::ST_STAB) ?
                srpc_pkg::ST_STAB : srpc_pkg::ST_RUN;
        end
        if (porSeen) begin
            state_d = srpc_pkg::ST_POR;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= srpc_pkg::ST_POR;
        end else if (clkEn) begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Prescaler and interval timer
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            psCnt_q <= '0;
            tapPrev_q <= 1'b0;
        end else if (clkEn) begin
            if (porSeen) begin
                psCnt_q <= '0;
                tapPrev_q <= 1'b0;
            end else if (psRun) begin
                psCnt_q <= psCnt_q + 1'b1;
                tapPrev_q <= tapNow;
            end
        end
    end

    // Interval counter cleared at stop entry and on resets
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bitCnt_q <= '0;
            ovfSeen_q <= 1'b0;
        end else if (clkEn) begin
            if (porSeen || extRstLow
                || state_d == srpc_pkg::ST_STOP) begin
                bitCnt_q <= '0;
                ovfSeen_q <= 1'b0;
            end else if (bitTick) begin
                bitCnt_q <= bitCnt_q + 1'b1;
                ovfSeen_q <= ovfSeen_q | bitOvf;
            end
        end
    end

    // ==========================================================
    // Brownout mode and stop-release qualification
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            brownout_q <= 1'b0;
            stopWakeOk_q <= 1'b0;
        end else if (clkEn) begin
            if (extRstLow || porSeen) begin
                brownout_q <= 1'b0;
            end else if (lowEvt) begin
                brownout_q <= 1'b1;
            end
            if (state_q == srpc_pkg::ST_RUN && stopCmd) begin
                stopWakeOk_q <= periphEn_q
                    || (intervalSel_q == srpc_pkg::SEL_TAP_TEN);
            end
        end
    end

    // ==========================================================
    // Supply indicator follows comparators both ways
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lvi_q <= 2'h0;
        end else if (clkEn) begin
            lvi_q <= {pinSync_q.belowLow, pinSync_q.belowHigh};
        end
    end

    // ==========================================================
    // Avalon slave: one wait cycle, then answer
    logic acc, wrHit;
    logic [31:0] rdMux;
    assign acc = avsRead || avsWrite;
    assign wrHit = avsWrite && !avsWaitRequest && avsByteEnable[0];
    always_comb begin
        rdMux = 32'h0000_0000;
        case (avsAddress)
            srpc_pkg::OFF_CTRL: rdMux[3:0] = {periphEn_q, intervalSel_q};
            srpc_pkg::OFF_LVI: rdMux[1:0] = lvi_q;
            srpc_pkg::OFF_IRQ_STAT: rdMux[3:0] = irqStat_q;
            srpc_pkg::OFF_IRQ_MASK: rdMux[3:0] = irqMask_q;
            srpc_pkg::OFF_STATE: rdMux[5:0] = {brownout_q, state_q};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // Bus handshake
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            avsWaitRequest <= 1'b1;
            avsReadData <= 32'h0000_0000;
        end else if (clkEn) begin
            avsWaitRequest <= !(acc && avsWaitRequest);
            if (avsRead && avsWaitRequest) begin
                avsReadData <= rdMux;
            end
        end
    end

    // Control and mask writes; release forces peripheral clock on
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            intervalSel_q <= srpc_pkg::RST_INTERVAL_SEL;
            periphEn_q <= srpc_pkg::RST_PERIPH_EN;
            irqMask_q <= srpc_pkg::RST_IRQ_MASK;
        end else if (clkEn) begin
            if (wrHit && avsAddress == srpc_pkg::OFF_CTRL) begin
                intervalSel_q <= avsWriteData[2:0];
                periphEn_q <= avsWriteData[srpc_pkg::CTRL_PCK_BIT];
            end else if (wakeStop || extRstLow) begin
                periphEn_q <= 1'b1;
            end
            if (wrHit && avsAddress == srpc_pkg::OFF_IRQ_MASK) begin
                irqMask_q <= avsWriteData[3:0];
            end
        end
    end

    // Sticky events, write one to clear, set wins
    assign evt = {state_q == srpc_pkg::ST_POR && bitOvf, lowEvt,
        refuse, wakeSleep || (state_q == srpc_pkg::ST_STAB && bitOvf)};
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irqStat_q <= 4'h0;
            irq <= 1'b0;
        end else if (clkEn) begin
            irqStat_q <= (irqStat_q & ~((wrHit && avsAddress
                == srpc_pkg::OFF_IRQ_STAT) ? avsWriteData[3:0] : 4'h0))
                | evt;
            irq <= |(irqStat_q & irqMask_q);
        end
    end

    // ==========================================================
    // Resume actions: vector or continue
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            resumeNext <= 1'b0;
            vectorTake <= 1'b0;
            vectorIndex <= '0;
        end else if (clkEn) begin
            resumeNext <= quiet && (wakeSleep || wakeStop)
                && !globalIrqEn;
            vectorTake <= quiet && (wakeSleep || wakeStop)
                && globalIrqEn;
            if (quiet && (wakeSleep || wakeStop)) begin
                vectorIndex <= firstSet(pend);
            end
        end
    end

    // Clock and oscillator outputs from next state; periphClkEn from periphEn_q, ports from brownout
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            clocks <= '0;
            osc <= '{oscRun: 1'b1, xoutHigh: 1'b0, xinLow: 1'b0,
                feedbackEn: 1'b1};
            sysReset <= 1'b1;
            portsAllInput <= 1'b0;
            brownoutMode <= 1'b0;
        end else if (clkEn) begin
            clocks.cpuClkEn <= (state_d == srpc_pkg::ST_RUN);
            clocks.prescalerRun <= (state_d != srpc_pkg::ST_STOP);
            clocks.intervalRun <= (state_d != srpc_pkg::ST_STOP)
                && (state_d != srpc_pkg::ST_SLEEP
                || intervalSel_q == srpc_pkg::SEL_TAP_TEN);
            clocks.periphClkEn <= periphEn_q;
            clocks.watchdogRun <= (state_d == srpc_pkg::ST_RUN);
            clocks.timerRun <= (state_d == srpc_pkg::ST_RUN)
                && periphEn_q;
            osc.oscRun <= (state_d != srpc_pkg::ST_STOP);
            osc.xoutHigh <= (state_d == srpc_pkg::ST_STOP);
            osc.xinLow <= (state_d == srpc_pkg::ST_STOP);
            osc.feedbackEn <= (state_d != srpc_pkg::ST_STOP);
            sysReset <= (state_d == srpc_pkg::ST_POR)
                || extRstLow || porSeen;
            portsAllInput <= lowEvt || (brownout_q
                && !extRstLow && !porSeen);
            brownoutMode <= lowEvt || (brownout_q
                && !extRstLow && !porSeen);
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    logic [31:0] porCycles_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            porCycles_q <= 32'h0;
        end else if (clkEn) begin
            if (state_q != srpc_pkg::ST_POR || porSeen) begin
                porCycles_q <= 32'h0;
            end else if (psRun) begin
                porCycles_q <= porCycles_q + 32'h1;
            end
        end
    end

    sequence s_wake;
        clkEn && quiet && (wakeSleep || wakeStop);
    endsequence
    sequence s_stopEntry;
        clkEn && quiet && state_q == srpc_pkg::ST_RUN && stopCmd
        && !anyPend;
    endsequence

    property p_refuse;
        clkEn && quiet && refuse |=> state_q == srpc_pkg::ST_RUN;
    endproperty
    a_refuse: assert property (p_refuse) else $error("standby entered");
    property p_resume;
        s_wake ##0 !globalIrqEn |=> resumeNext && !vectorTake;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume");
    property p_vector;
        s_wake ##0 globalIrqEn |=> vectorTake
            && vectorIndex == $past(firstSet(pend));
    endproperty
    a_vector: assert property (p_vector) else $error("no vector");
    property p_stopPark;
        s_stopEntry |=> !osc.oscRun && osc.xoutHigh && osc.xinLow
            && !osc.feedbackEn ##1 (!clkEn || $stable(psCnt_q));
    endproperty
    a_stopPark: assert property (p_stopPark) else $error("stop park");
    property p_porLen;
        clkEn && state_q == srpc_pkg::ST_POR
            && state_d == srpc_pkg::ST_RUN && !porSeen
            |-> porCycles_q == POR_LEN;
    endproperty
    a_porLen: assert property (p_porLen) else $error("por length");
    property p_porTap;
        state_q == srpc_pkg::ST_POR |-> tapIdx == 4'ha;
    endproperty
    a_porTap: assert property (p_porTap) else $error("por tap");
    property p_brownStop;
        clkEn && brownout_q && quiet && state_q == srpc_pkg::ST_STOP
            |=> state_q == srpc_pkg::ST_STOP && portsAllInput;
    endproperty
    a_brownStop: assert property (p_brownStop) else $error("lvd wake");
    property p_lvi;
        clkEn ##1 clkEn |-> lvi_q
            == $past({pinSync_q.belowLow, pinSync_q.belowHigh});
    endproperty
    a_lvi: assert property (p_lvi) else $error("indicator stale");
    property p_stab;
        clkEn && quiet && wakeStop |=> state_q == srpc_pkg::ST_STAB
            && periphEn_q && !clocks.cpuClkEn;
    endproperty
    a_stab: assert property (p_stab) else $error("stab entry");
    property p_lvdExit;
        clkEn && extRstLow |=> !brownout_q;
    endproperty
    a_lvdExit: assert property (p_lvdExit) else $error("lvd kept");
endmodule

// *** test/srpc_far_side.sv ***
// Far-side model: reset pin circuit, supply comparators, irq sources.
// Assumes the bench steers it from the mclk domain.
`timescale 1ns/1ps
module srpc_far_side #(
    parameter int HOLD = 8
) (
    // Clock
    input wire logic mclk,
    // Bench controls
    input wire logic oscOn,
    input wire logic [1:0] supplyLvl,
    input wire logic resetReq,
    input wire logic porReq,
    input wire logic [7:0] irqSet,
    // Toward the block
    output srpc_pkg::srpc_pins_t pins,
    output logic [7:0] irqReq
);
    int holdCnt = 0;

    // ==========================================================
    // Reset pin
    // Stretch each request well past two machine cycles
    always_ff @(posedge mclk) begin
        if (resetReq) begin
            holdCnt <= HOLD;
        end else if (holdCnt != 0) begin
            holdCnt <= holdCnt - 1;
        end
    end

    // ==========================================================
    // Comparators
    // Level 3 normal, 2 below high, 1 below low, 0 brownout
    always_comb begin
        pins.porPulse = porReq;
        pins.oscStarted = oscOn;
        pins.extResetB = holdCnt == 0 && !resetReq;
        pins.belowHigh = supplyLvl < 2'h3;
        pins.belowLow = supplyLvl < 2'h2;
        pins.supplyLow = supplyLvl == 2'h0;
        irqReq = irqSet;
    end
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the standby, reset and power block.
// Assumes the package and the far-side model are compiled first.
`timescale 1ns/1ps
module testbench;
    // ==========================================================
    // Signals
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic clkEn = 1'b1;
    logic [4:0] avsAddress = 5'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0;
    logic [3:0] avsByteEnable = 4'hf;
    logic [31:0] avsReadData;
    logic avsWaitRequest;
    srpc_pkg::srpc_pins_t pins;
    logic sleepCmd = 1'b0;
    logic stopCmd = 1'b0;
    logic globalIrqEn = 1'b0;
    logic [7:0] irqReq;
    logic [7:0] irqEnable = 8'hff;
    logic resumeNext, vectorTake, sysReset, portsAllInput, brownoutMode, irq;
    logic [2:0] vectorIndex;
    srpc_pkg::srpc_clocks_t clocks;
    srpc_pkg::srpc_osc_t osc;
    logic oscOn = 1'b0;
    logic [1:0] supplyLvl = 2'h3;
    logic resetReq = 1'b0;
    logic porReq = 1'b0;
    // Short interval counter keeps power-on within the run budget
    localparam int BITW = 4;
    localparam int PORLEN = int'(srpc_pkg::POR_CYCLES
        >> (srpc_pkg::BIT_WIDTH - BITW));
    localparam int TICK = 1 << (srpc_pkg::TAP_BASE + 1);
    localparam int STABMIN = ((1 << BITW) - 1) * TICK - 8;
    localparam int STABMAX = (1 << BITW) * TICK;
    logic [7:0] irqSet = 8'h00;
    logic [3:0] obs;
    logic [31:0] q;
    int n_mismatch = 0;
    int tests_run = 0;
    int wakes = 0;
    int n, w0;
    // Rows: supply level in [3:2], indicator value in [1:0]
    typedef struct packed {logic [1:0] lvl; logic [1:0] lvi;} srpc_row_t;
    srpc_row_t rows [4] = '{4'hc, 4'h9, 4'h7, 4'hc};

    // ==========================================================
    // Clock, instances, monitors
    always #4 mclk = ~mclk;
    srpc_ctrl #(.BIT_WIDTH(BITW)) srpc_ctrl_i (.mclk, .rst_b, .clkEn,
        .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable,
        .avsReadData, .avsWaitRequest, .pins, .sleepCmd, .stopCmd,
        .globalIrqEn, .irqReq, .irqEnable, .resumeNext, .vectorTake,
        .vectorIndex, .sysReset, .clocks, .osc, .portsAllInput,
        .brownoutMode, .irq);
    srpc_far_side srpc_far_side_i (.mclk, .oscOn, .supplyLvl, .resetReq,
        .porReq, .irqSet, .pins, .irqReq);
    assign obs = {brownoutMode, resumeNext | vectorTake, clocks.cpuClkEn,
        sysReset};
    // Count wake pulses
    always @(posedge mclk) begin
        if (resumeNext === 1'b1 || vectorTake === 1'b1) wakes++;
    end

    // ==========================================================
    // Tasks
    task automatic cyc(input int c);
        repeat (c) @(posedge mclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic fail(input string nm);
        n_mismatch++;
        $display("Error %s expected done seen timeout", nm);
        tally_and_finish;
    endtask
    task automatic bus(input logic isWr, input logic [4:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= isWr;
        avsRead <= !isWr;
        do begin
            cyc(1);
            k++;
        end while (avsWaitRequest !== 1'b0 && k < 20);
        if (avsWaitRequest !== 1'b0) fail("waitrequest");
        q = avsReadData;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        cyc(1);
    endtask
    task automatic regRd(input string nm, input logic [4:0] a,
        input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask
    task automatic waitw(input int b, input logic v, input int lim);
        n = 0;
        while (obs[b] !== v && n < lim) begin
            cyc(1);
            n++;
        end
        if (obs[b] !== v) fail("wait");
    endtask
    task automatic enter(input logic stop);
        sleepCmd <= !stop;
        stopCmd <= stop;
        cyc(1);
        sleepCmd <= 1'b0;
        stopCmd <= 1'b0;
        cyc(2);
    endtask
    task automatic wake(input logic [7:0] src, input logic vec,
        input logic [2:0] idx);
        irqSet <= src;
        waitw(2, 1'b1, 20);
        chk("resume", resumeNext, !vec);
        chk("vector", vectorTake, vec);
        if (vec) chk("index", vectorIndex, idx);
        irqSet <= 8'h00;
        cyc(2);
    endtask
    task automatic pinReset;
        resetReq <= 1'b1;
        cyc(1);
        resetReq <= 1'b0;
        waitw(0, 1'b1, 20);
        waitw(0, 1'b0, 40);
        waitw(1, 1'b1, 20000);
    endtask
    task automatic done(input string s);
        $display("Test %s done", s);
    endtask
    task automatic tally_and_finish;
        $display("Compared %0d, mismatched %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        cyc(2);
        chk("sysReset", sysReset, 1);
        chk("clocks", clocks, 0);
        rst_b <= 1'b1;
        cyc(1);
        // Indicator follows the supply both ways
        foreach (rows[i]) begin
            supplyLvl <= rows[i].lvl;
            cyc(6);
            regRd("lvi", srpc_pkg::OFF_LVI, rows[i].lvi);
        end
        done("indicator");
        regRd("ctrl", srpc_pkg::OFF_CTRL, 32'h0000000f);
        regRd("mask", srpc_pkg::OFF_IRQ_MASK, 32'h0);
        regRd("unmapped", 5'h1c, 32'h0);
        cyc(200);
        chk("porHold", sysReset, 1);
        oscOn <= 1'b1;
        waitw(0, 1'b0, PORLEN + 100);
        chk("porLen", n >= PORLEN && n <= PORLEN + 8, 1);
        regRd("state", srpc_pkg::OFF_STATE, 32'h01);
        regRd("porEvt", srpc_pkg::OFF_IRQ_STAT, 32'h08);
        bus(1'b1, srpc_pkg::OFF_IRQ_MASK, 32'h08);
        cyc(2);
        chk("irqSet", irq, 1);
        bus(1'b1, srpc_pkg::OFF_IRQ_STAT, 32'h08);
        cyc(2);
        chk("irqClr", irq, 0);
        done("power-on");
        enter(1'b0);
        chk("sleepClk", {clocks.cpuClkEn, clocks.prescalerRun,
            clocks.intervalRun, clocks.watchdogRun, clocks.timerRun},
            5'b01100);
        chk("sleepOsc", osc.oscRun, 1);
        wake(8'h04, 1'b0, 3'h0);
        globalIrqEn <= 1'b1;
        enter(1'b0);
        wake(8'h60, 1'b1, 3'h5);
        bus(1'b1, srpc_pkg::OFF_IRQ_STAT, 32'h0f);
        irqSet <= 8'h01;
        enter(1'b0);
        chk("refuseClk", clocks.cpuClkEn, 1);
        regRd("refuseEvt", srpc_pkg::OFF_IRQ_STAT, 32'h02);
        irqSet <= 8'h00;
        done("sleep");
        globalIrqEn <= 1'b0;
        bus(1'b1, srpc_pkg::OFF_CTRL, 32'h08);
        enter(1'b1);
        chk("stopOsc", osc, 4'b0110);
        chk("stopPs", clocks.prescalerRun, 0);
        wake(8'h02, 1'b0, 3'h0);
        waitw(1, 1'b1, 20000);
        chk("stabLen", n >= STABMIN && n <= STABMAX, 1);
        chk("stabPck", clocks.periphClkEn, 1);
        bus(1'b1, srpc_pkg::OFF_CTRL, 32'h00);
        enter(1'b1);
        w0 = wakes;
        irqSet <= 8'h02;
        cyc(60);
        chk("noWake", wakes - w0, 0);
        irqSet <= 8'h00;
        pinReset;
        chk("rstPck", clocks.periphClkEn, 1);
        done("stop");
        supplyLvl <= 2'h0;
        waitw(3, 1'b1, 10);
        chk("ports", portsAllInput, 1);
        regRd("lvdState", srpc_pkg::OFF_STATE, 32'h24);
        w0 = wakes;
        irqSet <= 8'h02;
        cyc(60);
        chk("lvdNoWake", wakes - w0, 0);
        irqSet <= 8'h00;
        supplyLvl <= 2'h3;
        cyc(4);
        pinReset;
        chk("lvdExit", brownoutMode, 0);
        done("brownout");
        porReq <= 1'b1;
        cyc(4);
        chk("porRst", sysReset, 1);
        porReq <= 1'b0;
        regRd("porState", srpc_pkg::OFF_STATE, 32'h10);
        done("power-on again");
        tally_and_finish;
    end
endmodule
